// ===== tb/idf_front_end_tb.sv
// testbench: front end against a queue model of the sample path
// assumes: host model drives the serial port and the sample pins
`timescale 1ns/1ps
`default_nettype none
module idf_front_end_tb
  import idf_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pll_en = 1'b0;
  logic lock = 1'b0;
  logic sclk, sel_n, sdi, vld, rdy, io_out, io_oe, so, so_oe;
  logic il_out, il_oe, dk_out, dk_oe, dac_valid, dac_enable, pv;
  logic [15:0] dac_i, dac_q, p1, p2, a, b;
  logic [7:0] q;
  logic [31:0] rs = 32'h0001_3ed5;
  logic [31:0] exq[$];
  logic mon = 1'b0;
  logic full_seen = 1'b0;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  wire io = io_oe ? io_out : sdi;
  wire il = il_oe ? il_out : p2[14];
  // host side data clock, one rising edge every eight cycles
  wire dk = dk_oe ? dk_out : cyc[2];
  always #50 clk = ~clk;
  idf_host_model host (.clk(clk), .sclk(sclk), .sel_n(sel_n), .sdi(sdi), .io_out(io_out),
    .io_oe(io_oe), .so(so), .so_oe(so_oe), .p1(p1), .p2(p2), .vld(vld), .rdy(rdy));
  idf_front_end #(.FIFO_DEPTH(4)) dut (.clk(clk), .rst(rst), .serial_clk(sclk),
    .serial_select_n(sel_n), .serial_io_in(io), .serial_io_out(io_out), .serial_io_oe(io_oe),
    .serial_out_data(so), .serial_out_oe(so_oe), .first_port_samples(p1),
    .second_port_samples(p2[13:0]), .channel_select_or_port2_msb(p2[15]),
    .interleave_clock_or_port2_bit_in(il), .interleave_clock_or_port2_bit_out(il_out),
    .interleave_clock_or_port2_bit_oe(il_oe), .data_clock_or_lock_pin_in(dk),
    .data_clock_or_lock_pin_out(dk_out), .data_clock_or_lock_pin_oe(dk_oe),
    .sample_valid(vld), .sample_ready(rdy), .pll_enable(pll_en), .pll_lock(lock),
    .dac_i(dac_i), .dac_q(dac_q), .dac_valid(dac_valid), .dac_enable(dac_enable));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic finish_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [4:0] ad, input logic [7:0] d);
    host.xfer(1'b0, ad, d, 16, q);
  endtask
  task automatic rchk(input logic [4:0] ad, input logic [7:0] e);
    host.xfer(1'b1, ad, 8'h00, 16, q);
    chk(q, e);
  endtask
  task automatic pwr(input logic [7:0] v, input logic [1:0] e);
    wr(ADR_SER, v);
    repeat (4) @(posedge clk);
    chk({dac_enable, dac_valid}, e);
  endtask
  // one port sends I then Q, two port sends one word a pair
  task automatic stream(input logic one, input logic uns, input int cnt);
    repeat (cnt) begin
      rs = lfsr(rs);
      a = rs[15:0] | 16'h0001;
      b = rs[31:16] | 16'h0001;
      exq.push_back({a ^ {uns, 15'h0000}, b ^ {uns, 15'h0000}});
      if (one) begin
        host.push(a, 16'h8000);
        host.push(b, 16'h0000);
      end else begin
        host.push(a, b);
      end
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (mon && dac_valid === 1'b1 && {dac_i, dac_q} !== 32'h0000_0000) begin
      chk({dac_i, dac_q}, exq.size() > 0 ? exq.pop_front() : 32'h0000_0000);
    end
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  always @(negedge clk) begin
    if (vld && rdy === 1'b0) full_seen = 1'b1;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rchk(ADR_SER, R0_RST);
    rchk(ADR_INT, R1_RST);
    rchk(ADR_FMT, R2_RST);
    rchk(5'h05, 8'h00);
    chk({so_oe, io_oe}, 2'b10);
    host.xfer(1'b0, ADR_INT, 8'hff, 12, q);
    rchk(ADR_INT, R1_RST);
    for (n = 0; n < 16; n++) begin
      rs = lfsr(rs);
      wr(ADR_INT, {n[3:0], rs[3:0]});
      rchk(ADR_INT, {n[3:0], rs[3:1], 1'b0});
    end
    wr(ADR_INT, 8'hc4);
    wr(ADR_FMT, 8'h40);
    chk(il_oe, 1'b1);
    @(negedge clk);
    pv = il_out;
    n = 0;
    repeat (16) begin
      @(negedge clk);
      if (il_out !== pv) n++;
      pv = il_out;
    end
    chk(n, 8);
    wr(ADR_FMT, 8'h00);
    @(negedge clk);
    pv = dk_out;
    n = 0;
    repeat (16) begin
      @(negedge clk);
      if (dk_out !== pv) n++;
      pv = dk_out;
    end
    chk(n, 4);
    stream(1'b0, 1'b0, 10);
    chk(full_seen, 1'b1);
    repeat (100) @(posedge clk);
    chk(rdy, 1'b1);
    exq.delete();
    wr(ADR_INT, 8'h04);
    wr(ADR_FMT, 8'hc0);
    repeat (50) @(posedge clk);
    mon <= 1'b1;
    stream(1'b1, 1'b1, 6);
    repeat (20) @(posedge clk);
    wr(ADR_FMT, 8'h00);
    chk(dk_oe, 1'b1);
    stream(1'b0, 1'b0, 6);
    repeat (20) @(posedge clk);
    mon <= 1'b0;
    chk(exq.size(), 0);
    wr(ADR_FMT, 8'h08);
    chk(dk_oe, 1'b0);
    mon <= 1'b1;
    stream(1'b0, 1'b0, 3);
    repeat (20) @(posedge clk);
    mon <= 1'b0;
    chk(exq.size(), 0);
    pll_en <= 1'b1;
    for (n = 0; n < 2; n++) begin
      lock <= n[0];
      repeat (2) @(posedge clk);
      chk({dk_oe, dk_out, il_oe}, {1'b1, n[0], 1'b0});
      rchk(ADR_SER, {6'h00, n[0], 1'b0});
    end
    pll_en <= 1'b0;
    lock <= 1'b0;
    pwr(8'h10, 2'b01);
    pwr(8'h08, 2'b00);
    pwr(8'h00, 2'b11);
    wr(ADR_INT, 8'hc8);
    wr(ADR_SER, 8'h60);
    rchk(ADR_SER, 8'h40);
    rchk(ADR_INT, R1_RST);
    wr(ADR_SER, 8'hc0);
    rchk(ADR_FMT, R2_RST);
    chk({so_oe, io_oe}, 2'b00);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    host.lsb = 1'b0;
    rchk(ADR_SER, R0_RST);
    finish_test();
  end
endmodule
`default_nettype wire

// ===== tb/idf_host_model.sv
// host model: serial control master and sample source
// assumes: pins sampled on clk, serial clock far slower than clk
`timescale 1ns/1ps
`default_nettype none
module idf_host_model (
  input wire logic clk,
  output logic sclk,
  output logic sel_n,
  output logic sdi,
  input wire logic io_out,
  input wire logic io_oe,
  input wire logic so,
  input wire logic so_oe,
  output logic [15:0] p1,
  output logic [15:0] p2,
  output logic vld,
  input wire logic rdy
);
  logic lsb = 1'b0;
  logic lastb = 1'b0;
  initial begin
    sclk = 1'b0;
    sel_n = 1'b1;
    sdi = 1'b0;
    p1 = 16'h0000;
    p2 = 16'h0000;
    vld = 1'b0;
  end
  // one bit: launch while low, capture just before the rise
  task automatic sbit(input logic b, output logic r);
    @(posedge clk);
    sclk <= 1'b0;
    sdi <= b;
    repeat (4) @(posedge clk);
    r = io_oe ? io_out : (so_oe ? so : ~lastb);
    lastb = r;
    sclk <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic xfer(input logic rd, input logic [4:0] a, input logic [7:0] d,
                      input int n, output logic [7:0] q);
    logic [7:0] ins;
    logic r;
    int k;
    int x;
    ins = {rd, 2'b00, a};
    q = 8'h00;
    @(posedge clk);
    sel_n <= 1'b0;
    for (k = 0; k < n; k++) begin
      x = lsb ? k % 8 : 7 - k % 8;
      sbit(k < 8 ? ins[x] : (rd ? ~sdi : d[x]), r);
      if (k >= 8) q[x] = r;
    end
    if (!rd && a == 5'h00 && n == 16) lsb = d[6];
    @(posedge clk);
    sclk <= 1'b0;
    sel_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  // hold the word until taken, then show the inverse
  task automatic push(input logic [15:0] a, input logic [15:0] b);
    @(posedge clk);
    p1 <= a;
    p2 <= b;
    vld <= 1'b1;
    do @(negedge clk); while (!rdy);
    @(posedge clk);
    vld <= 1'b0;
    p1 <= ~a;
    p2 <= ~b;
  endtask
endmodule
`default_nettype wire

// ===== verilog/idf_fifo.sv
// module: small sample fifo with honest full and empty
// assumes: synchronous active high reset, flush clears contents
`timescale 1ns/1ps
`default_nettype none
module idf_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  idf_stream_if.fifo s
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic wr, rd;

  assign s.push_ready = cnt_q != (AW+1)'(DEPTH);
  assign s.pop_valid = cnt_q != '0;
  assign s.pop_data = mem_q[rp_q];

  always_comb begin
    wr = s.push_valid && s.push_ready;
    rd = s.pop_valid && s.pop_ready;
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (wr) begin
      mem_d[wp_q] = s.push_data;
      wp_d = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
    end
    if (rd) begin
      rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
    end
    if (wr && !rd) begin
      cnt_d = cnt_q + 1'b1;
    end else if (rd && !wr) begin
      cnt_d = cnt_q - 1'b1;
    end
    if (rst || s.flush) begin
      wp_d = '0;
      rp_d = '0;
      cnt_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    mem_q <= mem_d;
    wp_q <= wp_d;
    rp_q <= rp_d;
    cnt_q <= cnt_d;
  end
endmodule
`default_nettype wire

// ===== verilog/idf_front_end.sv
// module: digital front end of a dual interpolating converter
// assumes: all pins synchronous to clk, serial clock slow against clk
// Overview of operation
// - reset pin restores every register incl address 0
// - soft reset bit restores others, keeps address 0
// - one port: select high latches I, low Q
// - pll off, one port: interleave clock driven out
// - pll on: shared pin shows lock state
// - pll off, two port: shared pin carries data clock
// - chip select high resets serial port logic
// - sample on serial rising, launch on falling
// - bidir bit steers sdio; separate output otherwise
// - bit order bit picks msb or lsb first
// - sleep bit switches converter output currents off
// - power down bit halts the datapath; serial port keeps working
// - address 1 bits 7:6 pick interpolation factor
// - interpolation codes 00 1x to 11 8x
// - address 1 bits 5:4 pick modulation
// - modulation codes none, fs/2, fs/4, fs/8
// - zero stuffing bit inserts zeros between inputs
// - mix bit picks real or complex mixing
// - rotation bit picks negative or positive frequency
// - coding bit picks signed or straight binary
// - port bit picks two ports or interleaved one
// - clock source bit picks internal or external
// - first halfband: 43 taps, centre 16384
// - second halfband: 19 taps, centre 8192
// - third halfband: 11 taps, centre 512
`timescale 1ns/1ps
`default_nettype none
module idf_front_end
  import idf_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_clk,
  input wire logic serial_select_n,
  input wire logic serial_io_in,
  output logic serial_io_out,
  output logic serial_io_oe,
  output logic serial_out_data,
  output logic serial_out_oe,
  input wire logic [15:0] first_port_samples,
  input wire logic [13:0] second_port_samples,
  input wire logic channel_select_or_port2_msb,
  input wire logic interleave_clock_or_port2_bit_in,
  output logic interleave_clock_or_port2_bit_out,
  output logic interleave_clock_or_port2_bit_oe,
  input wire logic data_clock_or_lock_pin_in,
  output logic data_clock_or_lock_pin_out,
  output logic data_clock_or_lock_pin_oe,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic pll_enable,
  input wire logic pll_lock,
  output logic [15:0] dac_i,
  output logic [15:0] dac_q,
  output logic dac_valid,
  output logic dac_enable
);

  function automatic logic [2:0] low_mask(int b);
    return 3'((1 << b) - 1);
  endfunction

  function automatic logic [15:0] conv(logic [15:0] x, logic u);
    return x ^ {u, 15'h0000};
  endfunction

  function automatic logic signed [15:0] sat16(logic signed [33:0] x);
    logic signed [33:0] y;
    y = x >>> TRIG_SHIFT;
    if (y > 34'sh0_0000_7fff) return 16'sh7fff;
    if (y < -34'sh0_0000_8000) return -16'sh8000;
    return 16'(y);
  endfunction

  function automatic logic signed [15:0] hb_eval(idf_hist_type h, int k, logic odd);
    logic signed [35:0] acc;
    acc = '0;
    if (!odd) begin
      acc = 36'(h[HB_HALF[k]]) * 36'(HB_CENTER[k]);
    end else begin
      for (int j = 0; j < HB_SIDES; j++) begin
        if (j < HB_HALF[k]) begin
          acc = acc + 36'(HB_COEF[k][j]) *
            (36'(h[HB_HALF[k] - 1 - j]) + 36'(h[HB_HALF[k] + j]));
        end
      end
    end
    return 16'(acc >>> HB_SHIFT[k]);
  endfunction

  // control registers
  logic [7:0] r0_q, r0_d, r1_q, r1_d, r2_q, r2_d;
  logic srst_q, srst_d;
  logic flush, run, lsbf, bidir, sleep, pdown, oneport, extclk, unsig;
  int n;

  // serial port state
  idf_spi_state_type st_q, st_d;
  logic [2:0] bcnt_q, bcnt_d;
  logic [7:0] sh_q, sh_d, obuf_q, obuf_d, rdv;
  logic [ADR_W-1:0] adr_q, adr_d;
  logic rd_q, rd_d, obit_q, obit_d, sclk_q, s_rise, s_fall, wr_en;

  // stream and datapath state
  idf_stream_if #(.W(32)) st ();
  logic [15:0] ihold_q, ihold_d;
  logic [2:0] cnt_q, cnt_d, ph, shf;
  logic dckin_q, take, slot, dck_q, dck_d, il_q, il_d;
  logic signed [15:0] samp [2];
  logic signed [15:0] stg_out [HB_STAGES][2];
  logic signed [15:0] pre [2];
  logic signed [15:0] di_q, di_d, dq_q, dq_d, cs, sn;
  logic signed [31:0] ic, qc, is, qs;
  logic [2:0] ang, step;
  logic dv_q, dv_d, den_q, den_d;

  assign lsbf = r0_q[B_LSB_FIRST];
  assign bidir = r0_q[B_SDIO_BIDIR];
  assign sleep = r0_q[B_SLEEP];
  assign pdown = r0_q[B_PDOWN];
  assign oneport = r2_q[B_ONEPORT];
  assign extclk = r2_q[B_EXTCLK];
  assign unsig = r2_q[B_UNSIGNED];
  assign n = int'(r1_q[B_INTERP_HI -: 2]);
  assign flush = rst || srst_q;
  assign run = !pdown && !flush;
  assign s_rise = serial_clk && !sclk_q;
  assign s_fall = !serial_clk && sclk_q;

  always_comb begin
    rdv = 8'h00;
    case (adr_q)
      ADR_SER: rdv = r0_q | ({7'h00, pll_lock} << B_LOCK);
      ADR_INT: rdv = r1_q;
      ADR_FMT: rdv = r2_q;
      default: rdv = 8'h00;
    endcase
  end

  // serial port sequencer
  always_comb begin
    st_d = st_q;
    bcnt_d = bcnt_q;
    sh_d = sh_q;
    rd_d = rd_q;
    adr_d = adr_q;
    obuf_d = obuf_q;
    obit_d = obit_q;
    wr_en = 1'b0;
    if (rst || serial_select_n) begin
      st_d = ST_INSTR;
      bcnt_d = '0;
      if (rst) begin
        obit_d = 1'b0;
        rd_d = 1'b0;
      end
    end else if (s_rise) begin
      sh_d = lsbf ? {serial_io_in, sh_q[7:1]} : {sh_q[6:0], serial_io_in};
      bcnt_d = bcnt_q + 3'h1;
      if (bcnt_q == 3'h7) begin
        case (st_q)
          ST_INSTR: begin
            st_d = ST_DATA;
            rd_d = sh_d[INSTR_RD];
            adr_d = sh_d[ADR_W-1:0];
          end
          ST_DATA: begin
            st_d = ST_INSTR;
            wr_en = !rd_q;
          end
          default: st_d = ST_INSTR;
        endcase
      end
    end else if (s_fall && st_q == ST_DATA && rd_q) begin
      obit_d = lsbf ? obuf_q[bcnt_q] : obuf_q[3'h7 - bcnt_q];
    end
    if (st_q == ST_INSTR && st_d == ST_DATA) begin
      obuf_d = 8'h00;
    end
    if (st_q == ST_DATA && bcnt_q == 3'h0 && !s_fall) begin
      obuf_d = rdv;
    end
  end

  always_ff @(posedge clk) begin
    st_q <= st_d;
    bcnt_q <= bcnt_d;
    sh_q <= sh_d;
    rd_q <= rd_d;
    adr_q <= adr_d;
    obuf_q <= obuf_d;
    obit_q <= obit_d;
    sclk_q <= serial_clk;
  end

  assign serial_io_out = obit_q;
  assign serial_io_oe = bidir && st_q == ST_DATA && rd_q;
  assign serial_out_data = obit_q;
  assign serial_out_oe = !bidir;

  // register file
  always_comb begin
    r0_d = r0_q;
    r1_d = r1_q;
    r2_d = r2_q;
    srst_d = 1'b0;
    if (rst) begin
      r0_d = R0_RST;
      r1_d = R1_RST;
      r2_d = R2_RST;
    end else if (wr_en) begin
      case (adr_q)
        ADR_SER: begin
          r0_d = sh_d & R0_WMASK;
          if (sh_d[B_SOFT_RST]) begin
            r1_d = R1_RST;
            r2_d = R2_RST;
            srst_d = 1'b1;
          end
        end
        ADR_INT: r1_d = sh_d & R1_WMASK;
        ADR_FMT: r2_d = sh_d & R2_WMASK;
        default: r1_d = r1_q;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    r0_q <= r0_d;
    r1_q <= r1_d;
    r2_q <= r2_d;
    srst_q <= srst_d;
  end

  // sample capture into the fifo
  assign take = !(!pll_enable && !oneport && extclk) ||
    (data_clock_or_lock_pin_in && !dckin_q);
  assign sample_ready = take && ((oneport && channel_select_or_port2_msb) || st.push_ready);
  assign st.flush = flush;

  always_comb begin
    ihold_d = ihold_q;
    st.push_valid = 1'b0;
    st.push_data = '0;
    if (oneport) begin
      if (sample_valid && take && channel_select_or_port2_msb) begin
        ihold_d = first_port_samples;
      end
      st.push_valid = sample_valid && take && !channel_select_or_port2_msb;
      st.push_data = {conv(ihold_q, unsig), conv(first_port_samples, unsig)};
    end else begin
      st.push_valid = sample_valid && take;
      st.push_data = {conv(first_port_samples, unsig),
        conv({channel_select_or_port2_msb, interleave_clock_or_port2_bit_in,
        second_port_samples}, unsig)};
    end
    if (rst) begin
      ihold_d = '0;
    end
  end

  idf_fifo #(.W(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .s(st)
  );

  // rate slots: stage k runs at 2^(k+1) per input sample
  always_comb begin
    ph = '0;
    shf = '0;
    for (int k = 0; k < HB_STAGES; k++) begin
      if (k < n) begin
        ph[k] = cnt_q[n - k - 1];
        shf[k] = run && (cnt_q & low_mask(n - k)) == 3'h0;
      end
    end
  end

  assign slot = run && (cnt_q & low_mask(n)) == 3'h0;
  assign st.pop_ready = slot;
  assign samp[0] = (slot && st.pop_valid) ? st.pop_data[31:16] : 16'sh0000;
  assign samp[1] = (slot && st.pop_valid) ? st.pop_data[15:0] : 16'sh0000;

  for (genvar k = 0; k < HB_STAGES; k++) begin : g_stg
    for (genvar c = 0; c < 2; c++) begin : g_ch
      idf_hist_type h_q, h_d;
      logic signed [15:0] din;
      if (k == 0) begin : g_first
        assign din = samp[c];
      end else begin : g_next
        assign din = stg_out[k-1][c];
      end
      always_comb begin
        h_d = h_q;
        if (flush) begin
          h_d = '{default: 16'sh0000};
        end else if (shf[k]) begin
          for (int j = HB_HIST - 1; j > 0; j--) begin
            h_d[j] = h_q[j-1];
          end
          h_d[0] = din;
        end
      end
      always_ff @(posedge clk) begin
        h_q <= h_d;
      end
      assign stg_out[k][c] = (r1_q[B_ZSTUFF] && ph[k]) ? 16'sh0000 : hb_eval(h_q, k, ph[k]);
    end
  end

  assign pre[0] = (n == 0) ? samp[0] : stg_out[n-1][0];
  assign pre[1] = (n == 0) ? samp[1] : stg_out[n-1][1];

  // digital modulation after interpolation
  always_comb begin
    case (r1_q[B_MOD_HI -: 2])
      2'b01: step = 3'h4;
      2'b10: step = 3'h2;
      2'b11: step = 3'h1;
      default: step = 3'h0;
    endcase
    ang = 3'(cnt_q * step);
    cs = SIN8[3'(ang + 3'h2)];
    sn = SIN8[ang];
    ic = pre[0] * cs;
    qc = pre[1] * cs;
    is = pre[0] * sn;
    qs = pre[1] * sn;
    if (step == 3'h0) begin
      di_d = pre[0];
      dq_d = pre[1];
    end else if (r1_q[B_REALMIX]) begin
      di_d = sat16(34'(ic));
      dq_d = sat16(34'(qc));
    end else if (r1_q[B_ROT_POS]) begin
      di_d = sat16(34'(ic) - 34'(qs));
      dq_d = sat16(34'(qc) + 34'(is));
    end else begin
      di_d = sat16(34'(ic) + 34'(qs));
      dq_d = sat16(34'(qc) - 34'(is));
    end
    if (!run || sleep) begin
      di_d = 16'sh0000;
      dq_d = 16'sh0000;
    end
    dv_d = run;
    den_d = !sleep && !pdown && !rst;
    cnt_d = run ? cnt_q + 3'h1 : 3'h0;
    dck_d = dck_q;
    il_d = il_q;
    if (run && (cnt_q & low_mask(n > 0 ? n - 1 : 0)) == 3'h0) begin
      dck_d = !dck_q;
    end
    if (run && (cnt_q & low_mask(n > 1 ? n - 2 : 0)) == 3'h0) begin
      il_d = !il_q;
    end
    if (flush) begin
      dck_d = 1'b0;
      il_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    di_q <= di_d;
    dq_q <= dq_d;
    dv_q <= dv_d;
    den_q <= den_d;
    cnt_q <= cnt_d;
    dck_q <= dck_d;
    il_q <= il_d;
    ihold_q <= ihold_d;
    dckin_q <= data_clock_or_lock_pin_in;
  end

  assign dac_i = di_q;
  assign dac_q = dq_q;
  assign dac_valid = dv_q;
  assign dac_enable = den_q;

  // shared pins
  assign data_clock_or_lock_pin_out = pll_enable ? pll_lock : dck_q;
  assign data_clock_or_lock_pin_oe = pll_enable || (!oneport && !extclk);
  assign interleave_clock_or_port2_bit_out = il_q;
  assign interleave_clock_or_port2_bit_oe = !pll_enable && oneport;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_hw_reset_defaults: assert property (
    $fell(rst) |-> r0_q == R0_RST && r1_q == R1_RST && r2_q == R2_RST)
    else $error("registers not at defaults after reset");
  chk_soft_reset_scope: assert property (
    wr_en && adr_q == ADR_SER && sh_d[B_SOFT_RST] |=>
    r1_q == R1_RST && r2_q == R2_RST && !r0_q[B_SOFT_RST] && r0_q[B_LSB_FIRST] == $past(sh_d[6]))
    else $error("soft reset scope wrong");
  chk_select_resets_port: assert property (
    serial_select_n |=> st_q == ST_INSTR && bcnt_q == 3'h0)
    else $error("serial port not reset by select");
  chk_sdo_tristate: assert property (
    serial_io_oe |-> !serial_out_oe && bidir)
    else $error("both serial outputs driven");
  chk_sleep_output_off: assert property (
    sleep ##1 sleep |-> !dac_enable && dac_i == 16'h0000 && dac_q == 16'h0000)
    else $error("output active in sleep");
  chk_pdown_halts: assert property (
    pdown |-> (!st.pop_ready) ##1 (!dac_valid && cnt_q == 3'h0))
    else $error("datapath runs in power down");
  chk_oneport_i_latch: assert property (
    oneport && sample_valid && take && channel_select_or_port2_msb |->
    !st.push_valid ##1 ihold_q == $past(first_port_samples))
    else $error("I word not latched");
  chk_lock_on_pin: assert property (
    pll_enable |-> data_clock_or_lock_pin_oe && data_clock_or_lock_pin_out == pll_lock)
    else $error("lock state not on shared pin");
  chk_x4_pop_spacing: assert property (
    run && n == 2 && slot ##1 run && n == 2 |-> !slot ##1 !slot ##1 !slot)
    else $error("pop spacing wrong for 4x");
  chk_zero_stuff: assert property (
    r1_q[B_ZSTUFF] && n > 0 && ph[n-1] |-> pre[0] == 16'sh0000 && pre[1] == 16'sh0000)
    else $error("odd phase not zero while stuffing");
endmodule
`default_nettype wire

// ===== verilog/idf_pkg.sv
// package: register map, field positions, reset values, filter and mixer tables
// assumes: compiled before every other file of the front end
package idf_pkg;

  // serial register addresses
  localparam logic [4:0] ADR_SER = 5'h00;
  localparam logic [4:0] ADR_INT = 5'h01;
  localparam logic [4:0] ADR_FMT = 5'h02;

  // instruction byte: read flag position, address field width
  localparam int INSTR_RD = 7;
  localparam int ADR_W = 5;

  // serial_and_power_control fields
  localparam int B_SDIO_BIDIR = 7;
  localparam int B_LSB_FIRST = 6;
  localparam int B_SOFT_RST = 5;
  localparam int B_SLEEP = 4;
  localparam int B_PDOWN = 3;
  localparam int B_LOCK = 1;

  // interpolation_modulation_control fields
  localparam int B_INTERP_HI = 7;
  localparam int B_MOD_HI = 5;
  localparam int B_ZSTUFF = 3;
  localparam int B_REALMIX = 2;
  localparam int B_ROT_POS = 1;

  // input_data_format_control fields
  localparam int B_UNSIGNED = 7;
  localparam int B_ONEPORT = 6;
  localparam int B_EXTCLK = 3;

  // reset values and writable bits
  localparam logic [7:0] R0_RST = 8'h00;
  localparam logic [7:0] R1_RST = 8'h04;
  localparam logic [7:0] R2_RST = 8'h00;
  localparam logic [7:0] R0_WMASK = 8'hdc;
  localparam logic [7:0] R1_WMASK = 8'hfe;
  localparam logic [7:0] R2_WMASK = 8'he8;

  // serial port sequencer
  typedef enum logic [1:0] {
    ST_INSTR = 2'b01,
    ST_DATA = 2'b10
  } idf_spi_state_type;

  // halfband stages: side taps from the centre outward, centre tap, scale
  localparam int HB_STAGES = 3;
  localparam int HB_SIDES = 11;
  localparam int HB_HIST = 22;
  typedef logic signed [15:0] idf_hist_type [HB_HIST];
  typedef int idf_coef_type [HB_STAGES][HB_SIDES];
  typedef int idf_stage_type [HB_STAGES];
  localparam idf_coef_type HB_COEF = '{
    '{10364, -3280, 1772, -1079, 673, -414, 244, -134, 67, -29, 8},
    '{5047, -1288, 438, -120, 19, 0, 0, 0, 0, 0, 0},
    '{302, -53, 7, 0, 0, 0, 0, 0, 0, 0, 0}
  };
  localparam idf_stage_type HB_CENTER = '{16384, 8192, 512};
  localparam idf_stage_type HB_HALF = '{11, 5, 3};
  localparam idf_stage_type HB_SHIFT = '{14, 13, 9};

  // sine in eighth turns, q15
  typedef logic signed [15:0] idf_trig_type [8];
  localparam idf_trig_type SIN8 = '{
    16'sh0000, 16'sh5a82, 16'sh7fff, 16'sh5a82,
    16'sh0000, -16'sh5a82, -16'sh7fff, -16'sh5a82
  };
  localparam int TRIG_SHIFT = 15;

endpackage

// ===== verilog/idf_stream_if.sv
// interface: sample pair stream between the front end and its fifo
// assumes: one clock, user side pushes converted pairs and pops them
`timescale 1ns/1ps
`default_nettype none
interface idf_stream_if #(
  parameter int W = 32
);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;
  logic flush;
  modport fifo (
    input push_valid, push_data, pop_ready, flush,
    output push_ready, pop_valid, pop_data
  );
  modport user (
    output push_valid, push_data, pop_ready, flush,
    input push_ready, pop_valid, pop_data
  );
endinterface
`default_nettype wire
